// File: dv/tcm_timer_compare_tb.sv
`timescale 1ns/10ps
module tcm_timer_compare_tb;
  import tcm_pkg::*;

  // ==========================================================
  // signals
  logic aclk;
  logic aresetn;
  logic [7:0] awaddr;
  logic [7:0] araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp;
  logic [1:0] rresp;
  logic in_one, in_two, in_trg, etr;
  logic ref1, ref2, cap1, cap2, upd;
  logic [33:0] exp_q[$];
  int err_total;
  int n_checks;
  int h1;
  int h2;
  int n_upd;
  logic [31:0] d;
  logic [2:0] md[4] = '{3'b110, 3'b001, 3'b010, 3'b011};
  int hi[4] = '{50, 100, 0, 50};

  tcm_timer_compare tcm_timer_compare_i (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid),
    .s_axi_awready(awready),
    .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid),
    .s_axi_wready(wready),
    .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid),
    .s_axi_bready(bready),
    .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid),
    .s_axi_arready(arready),
    .s_axi_rdata(rdata),
    .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid),
    .s_axi_rready(rready),
    .timer_input_one(in_one),
    .timer_input_two(in_two),
    .internal_trigger_source(in_trg),
    .filtered_external_trigger(etr),
    .ch1_reference_output(ref1),
    .ch2_reference_output(ref2),
    .ch1_capture_input(cap1),
    .ch2_capture_input(cap2),
    .update_event(upd)
  );

  // ==========================================================
  // checking
  task automatic chk(input logic [33:0] e, input logic [33:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t: expected %h got %h", $time, e, g);
    end
  endtask

  // responses are matched against the oldest note, one transfer is in flight at a time
  always @(posedge aclk) begin
    if (bvalid && bready) chk(exp_q.pop_front(), {bresp, 32'h0});
    if (rvalid && rready) chk(exp_q.pop_front(), {rresp, rdata});
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic tend(input string s);
    $display("test %s finished", s);
  endtask

  // ==========================================================
  // bus master
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    input logic [1:0] r = TCM_RESP_OKAY);
    exp_q.push_back({r, 32'h0});
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] r = TCM_RESP_OKAY);
    exp_q.push_back({r, e});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
  endtask

  // ==========================================================
  // clock and watchdog
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // the whole sequence needs roughly a thousand cycles
  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    test_done();
  end

  // ==========================================================
  // tests
  initial begin
    aresetn = 1'b0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {in_one, in_two, in_trg, etr} = '0;
    void'($urandom(32'hD7F1));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;

    rd(TCM_OFF_CHMODE, 32'h0);
    rd(TCM_OFF_ARR, 32'h0000FFFF);
    rd(TCM_OFF_STAT, 32'h0);
    tend("reset values");

    repeat (4) begin
      d = $urandom;
      d[1:0] = 2'b00;
      d[9:8] = 2'b00;
      wr(TCM_OFF_CHMODE, d);
      rd(TCM_OFF_CHMODE, {16'h0, d[15:0]});
    end
    tend("field layout");

    for (int m = 4; m < 6; m++) begin
      wr(TCM_OFF_CHMODE, 32'((m << 4) | (m << 12)));
      repeat (3) @(posedge aclk);
      rd(TCM_OFF_STAT, (m == 5) ? 32'h3 : 32'h0);
    end
    tend("forced levels");

    // clear enable on channel 1 only, so channel 2 shows the gate is per channel
    wr(TCM_OFF_CHMODE, 32'h50D0);
    etr <= 1'b1;
    repeat (4) @(posedge aclk);
    rd(TCM_OFF_STAT, 32'h2);
    etr <= 1'b0;
    repeat (4) @(posedge aclk);
    rd(TCM_OFF_STAT, 32'h3);
    tend("external clear");

    in_one <= 1'b1;
    in_trg <= 1'b1;
    for (int dir = 1; dir < 4; dir++) begin
      wr(TCM_OFF_CHMODE, 32'(dir | (dir << 8)));
      repeat (4) @(posedge aclk);
      rd(TCM_OFF_STAT, {28'h0, dir != 1, dir != 2, 2'b00});
      chk(34'({dir != 1, dir != 2}), 34'({cap2, cap1}));
    end
    in_one <= 1'b0;
    in_trg <= 1'b0;
    wr(TCM_OFF_CHMODE, 32'h0);
    tend("input select");

    wr(TCM_OFF_CHEN, 32'h11);
    wr(TCM_OFF_CHMODE, 32'h0101);
    rd(TCM_OFF_CHMODE, 32'h0);
    wr(TCM_OFF_CHEN, 32'h0);
    tend("direction lock");

    wr(TCM_OFF_ARR, 32'h9);
    wr(TCM_OFF_CTRL, 32'h2);
    wr(TCM_OFF_EVGEN, 32'h1);
    rd(TCM_OFF_CNT, 32'h9);
    wr(TCM_OFF_CTRL, 32'h0);
    wr(TCM_OFF_EVGEN, 32'h1);
    rd(TCM_OFF_CNT, 32'h0);
    tend("update event");

    // period of ten counts; a window of 100 cycles holds exactly ten periods
    wr(TCM_OFF_CMP1, 32'h5);
    wr(TCM_OFF_CMP2, 32'h5);
    wr(TCM_OFF_CTRL, 32'h1);
    for (int i = 0; i < 4; i++) begin
      wr(TCM_OFF_CHMODE, 32'h7000 | {25'h0, md[i], 4'h0});
      repeat (30) @(posedge aclk);
      h1 = 0;
      h2 = 0;
      n_upd = 0;
      repeat (100) begin
        @(posedge aclk);
        h1 += int'(ref1);
        h2 += int'(ref2);
        n_upd += int'(upd);
      end
      chk(34'd10, 34'(n_upd));
      chk(34'(hi[i]), 34'(h1));
      chk(34'd40, 34'(h2));
    end
    wr(TCM_OFF_CTRL, 32'h0);
    tend("compare modes");

    // counter parked at 9 and compare 1 at 0: only the restart can make the match
    for (int f = 0; f < 2; f++) begin
      wr(TCM_OFF_CTRL, 32'h2);
      wr(TCM_OFF_EVGEN, 32'h1);
      wr(TCM_OFF_CTRL, 32'h0);
      wr(TCM_OFF_CMP1, 32'h0);
      wr(TCM_OFF_CHMODE, 32'h4040);
      wr(TCM_OFF_CHMODE, 32'h10 | 32'(f << 2));
      in_trg <= 1'b1;
      do @(posedge aclk); while (!upd);
      chk(34'(f), 34'(ref1));
      in_trg <= 1'b0;
    end
    tend("fast response");

    wr(TCM_OFF_EVGEN, 32'h1);
    wr(TCM_OFF_CMP1, 32'h3);
    wr(TCM_OFF_CHMODE, 32'h0);
    wr(TCM_OFF_CHMODE, 32'h68);
    wr(TCM_OFF_CMP1, 32'h0);
    rd(TCM_OFF_STAT, 32'h1);
    wr(TCM_OFF_EVGEN, 32'h1);
    rd(TCM_OFF_STAT, 32'h0);
    tend("preload");

    rd(8'h40, 32'h0, TCM_RESP_SLVERR);
    wr(8'h40, 32'h1, TCM_RESP_SLVERR);
    tend("unmapped");

    // the lock level stays set until the reset that follows
    wr(TCM_OFF_CHMODE, 32'h5050);
    wr(TCM_OFF_CTRL, 32'h30);
    wr(TCM_OFF_CHMODE, 32'h48C8);
    rd(TCM_OFF_CHMODE, 32'h50D0);
    tend("protection");

    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(TCM_OFF_CHMODE, 32'h0);
    rd(TCM_OFF_STAT, 32'h0);
    tend("second reset");
    test_done();
  end
endmodule

// File: src/tcm_pkg.sv
package tcm_pkg;

  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] TCM_OFF_CTRL = 8'h00;
  localparam logic [7:0] TCM_OFF_EVGEN = 8'h14;
  localparam logic [7:0] TCM_OFF_CHMODE = 8'h18;
  localparam logic [7:0] TCM_OFF_CHEN = 8'h20;
  localparam logic [7:0] TCM_OFF_CNT = 8'h24;
  localparam logic [7:0] TCM_OFF_PSC = 8'h28;
  localparam logic [7:0] TCM_OFF_ARR = 8'h2C;
  localparam logic [7:0] TCM_OFF_CMP1 = 8'h34;
  localparam logic [7:0] TCM_OFF_CMP2 = 8'h38;
  localparam logic [7:0] TCM_OFF_STAT = 8'h3C;

  // ==========================================================
  // field positions
  localparam int unsigned TCM_CTRL_CNT_EN = 0;
  localparam int unsigned TCM_CTRL_DOWN = 1;
  localparam int unsigned TCM_CTRL_SPM = 2;
  localparam int unsigned TCM_CTRL_PROT_LSB = 4;
  localparam int unsigned TCM_EVGEN_UEG = 0;
  localparam int unsigned TCM_CHEN_CH1 = 0;
  localparam int unsigned TCM_CHEN_CH2 = 4;
  localparam int unsigned TCM_CM_DIR_LSB = 0;
  localparam int unsigned TCM_CM_FEN = 2;
  localparam int unsigned TCM_CM_PEN = 3;
  localparam int unsigned TCM_CM_MODE_LSB = 4;
  localparam int unsigned TCM_CM_CEN = 7;
  localparam int unsigned TCM_CH_STRIDE = 8;

  // ==========================================================
  // reset values and codes
  localparam logic [15:0] TCM_RST_CHMODE = 16'h0000;
  localparam logic [15:0] TCM_RST_ARR = 16'hFFFF;
  localparam logic [15:0] TCM_RST_PSC = 16'h0000;
  localparam logic [1:0] TCM_PROT_LOCK = 2'h3;
  localparam logic [1:0] TCM_RESP_OKAY = 2'h0;
  localparam logic [1:0] TCM_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    TCM_DIR_OUT = 2'b00,
    TCM_DIR_IN_OWN = 2'b01,
    TCM_DIR_IN_OTHER = 2'b10,
    TCM_DIR_IN_TRG = 2'b11
  } tcm_dir_e;

  typedef enum logic [2:0] {
    TCM_MODE_FREEZE = 3'b000,
    TCM_MODE_MATCH_HIGH = 3'b001,
    TCM_MODE_MATCH_LOW = 3'b010,
    TCM_MODE_MATCH_TOGGLE = 3'b011,
    TCM_MODE_FORCE_LOW = 3'b100,
    TCM_MODE_FORCE_HIGH = 3'b101,
    TCM_MODE_PWM1 = 3'b110,
    TCM_MODE_PWM2 = 3'b111
  } tcm_mode_e;

endpackage

// File: src/tcm_timer_compare.sv
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/10ps
// How it works
// - every bit except direction and preload enable means something different for input and output channels
// - channel 1 direction: 00 output, 01 input one, 10 input two, 11 trigger
// - channel 2 direction: 00 output, 01 input two, 10 input one, 11 trigger
// - direction field writes take effect only while the channel enable bit is clear
// - fast enable shortens trigger-to-reference-output delay
// - preload off: compare write acts at once; on: at next update event
// - protection level 3 on an output channel locks preload bit and mode field
// - mode 000 freezes the reference output at its level
// - mode 001 drives reference high on counter match
// - mode 010 drives reference low on counter match
// - mode 011 toggles reference on each counter match
// - mode 100 forces reference low, mode 101 forces it high
// - mode 110 drives high while counter below compare value, else low
// - mode 111 drives high while counter above compare value, else low
// - PWM level updates only on compare change or freeze-to-PWM mode change
// - clear enable forces reference low while filtered external trigger is high
// - channel 2 fields sit at bits 9:8, 10, 11, 14:12 and 15
// - update event clears prescaler count, keeps factor, reloads counter
module tcm_timer_compare
  import tcm_pkg::*;
#(
  parameter int unsigned CW = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic timer_input_one,
  input wire logic timer_input_two,
  input wire logic internal_trigger_source,
  input wire logic filtered_external_trigger,
  output logic ch1_reference_output,
  output logic ch2_reference_output,
  output logic ch1_capture_input,
  output logic ch2_capture_input,
  output logic update_event
);

  // ==========================================================
  // state
  typedef struct packed {
    logic awv;
    logic [7:0] awa;
    logic wv;
    logic [31:0] wd;
    logic [3:0] ws;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic cnt_en, down, spm;
    logic [1:0] prot;
    logic [15:0] chmode;
    logic [1:0] chen;
    logic [CW-1:0] cnt, psc, psc_cnt, arr;
    logic [1:0][CW-1:0] cmp_pre, cmp_act;
    logic [1:0] lvl, ref_o, eq_prev, pwm_prev;
    logic [1:0][2:0] mode_prev;
    logic [1:0] cap;
    logic uev;
    logic [3:0] s1, s2, s3;
  } tcm_state_s;

  tcm_state_s s;
  tcm_state_s next_s;
  logic wr_go, ueg_wr, trg_edge, ovf, ug;
  logic [31:0] wm;
  logic [CW-1:0] start_val, cnt_cmp;
  logic [1:0] eq, lt, gt, pwm_res, clr, fen, pen;
  logic [1:0][1:0] dir_cur;
  logic [1:0][2:0] mode_cur;
  logic [7:0] cm_old, cm_new;

  function automatic logic [31:0] tcm_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) r[b*8 +: 8] = nw[b*8 +: 8];
    end
    return r;
  endfunction

  // channel 2 sees its own and the other timer input swapped against channel 1
  function automatic logic tcm_pick(input logic ch2, input logic [1:0] dir,
                                    input logic [3:0] v);
    logic r;
    case (dir)
      TCM_DIR_IN_OWN: r = ch2 ? v[1] : v[0];
      TCM_DIR_IN_OTHER: r = ch2 ? v[0] : v[1];
      TCM_DIR_IN_TRG: r = v[2];
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  function automatic logic [31:0] tcm_read(input tcm_state_s st, input logic [7:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (a)
      TCM_OFF_CTRL: begin
        r[TCM_CTRL_CNT_EN] = st.cnt_en;
        r[TCM_CTRL_DOWN] = st.down;
        r[TCM_CTRL_SPM] = st.spm;
        r[TCM_CTRL_PROT_LSB +: 2] = st.prot;
      end
      TCM_OFF_CHMODE: r[15:0] = st.chmode;
      TCM_OFF_CHEN: begin
        r[TCM_CHEN_CH1] = st.chen[0];
        r[TCM_CHEN_CH2] = st.chen[1];
      end
      TCM_OFF_CNT: r[CW-1:0] = st.cnt;
      TCM_OFF_PSC: r[CW-1:0] = st.psc;
      TCM_OFF_ARR: r[CW-1:0] = st.arr;
      TCM_OFF_CMP1: r[CW-1:0] = st.cmp_pre[0];
      TCM_OFF_CMP2: r[CW-1:0] = st.cmp_pre[1];
      TCM_OFF_STAT: r[3:0] = {st.cap, st.ref_o};
      default: r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  function automatic logic tcm_mapped(input logic [7:0] a);
    return (a == TCM_OFF_CTRL) || (a == TCM_OFF_EVGEN) || (a == TCM_OFF_CHMODE) ||
           (a == TCM_OFF_CHEN) || (a == TCM_OFF_CNT) || (a == TCM_OFF_PSC) ||
           (a == TCM_OFF_ARR) || (a == TCM_OFF_CMP1) || (a == TCM_OFF_CMP2) ||
           (a == TCM_OFF_STAT);
  endfunction

  // ==========================================================
  // bus handshakes
  assign s_axi_awready = !s.awv && !s.bvalid;
  assign s_axi_wready = !s.wv && !s.bvalid;
  assign s_axi_arready = !s.rvalid;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign ch1_reference_output = s.ref_o[0];
  assign ch2_reference_output = s.ref_o[1];
  assign ch1_capture_input = s.cap[0];
  assign ch2_capture_input = s.cap[1];
  assign update_event = s.uev;

  // ==========================================================
  // next state
  always_comb begin
    next_s = s;
    cm_old = 8'h00;
    cm_new = 8'h00;
    next_s.s1 = {filtered_external_trigger, internal_trigger_source,
                 timer_input_two, timer_input_one};
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;

    wr_go = s.awv && s.wv && !s.bvalid;
    ueg_wr = wr_go && (s.awa == TCM_OFF_EVGEN) && s.ws[0] && s.wd[TCM_EVGEN_UEG];
    trg_edge = s.s2[2] && !s.s3[2];
    start_val = s.down ? s.arr : '0;
    ovf = 1'b0;

    if (s_axi_awvalid && s_axi_awready) begin
      next_s.awv = 1'b1;
      next_s.awa = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_s.wv = 1'b1;
      next_s.wd = s_axi_wdata;
      next_s.ws = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready) next_s.bvalid = 1'b0;
    if (s.rvalid && s_axi_rready) next_s.rvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready) begin
      next_s.rvalid = 1'b1;
      next_s.rdata = tcm_read(s, s_axi_araddr);
      next_s.rresp = tcm_mapped(s_axi_araddr) ? TCM_RESP_OKAY : TCM_RESP_SLVERR;
    end

    // counter and prescaler
    if (s.cnt_en) begin
      if (s.psc_cnt == s.psc) begin
        next_s.psc_cnt = '0;
        if (!s.down) begin
          ovf = (s.cnt == s.arr);
          next_s.cnt = ovf ? '0 : s.cnt + 1'b1;
        end else begin
          ovf = (s.cnt == '0);
          next_s.cnt = ovf ? s.arr : s.cnt - 1'b1;
        end
      end else begin
        next_s.psc_cnt = s.psc_cnt + 1'b1;
      end
    end
    // the trigger input restarts the counter, which is what fast enable races
    ug = ovf || ueg_wr || trg_edge;
    if (ug) begin
      next_s.psc_cnt = '0;
      next_s.cmp_act = s.cmp_pre;
    end
    if (ueg_wr || trg_edge) next_s.cnt = start_val;
    if (ovf && s.spm) next_s.cnt_en = 1'b0;
    next_s.uev = ug;

    // channels: field meaning depends on the direction
    for (int c = 0; c < 2; c++) begin
      dir_cur[c] = s.chmode[c*TCM_CH_STRIDE + TCM_CM_DIR_LSB +: 2];
      mode_cur[c] = s.chmode[c*TCM_CH_STRIDE + TCM_CM_MODE_LSB +: 3];
      fen[c] = s.chmode[c*TCM_CH_STRIDE + TCM_CM_FEN];
      pen[c] = s.chmode[c*TCM_CH_STRIDE + TCM_CM_PEN];
      clr[c] = s.chmode[c*TCM_CH_STRIDE + TCM_CM_CEN] && s.s2[3];
      // fast path compares against the value the counter is about to load
      cnt_cmp = (trg_edge && fen[c]) ? start_val : s.cnt;
      eq[c] = (cnt_cmp == s.cmp_act[c]);
      lt[c] = (cnt_cmp < s.cmp_act[c]);
      gt[c] = (cnt_cmp > s.cmp_act[c]);
      pwm_res[c] = (mode_cur[c] == TCM_MODE_PWM1) ? lt[c] : gt[c];
      next_s.cap[c] = tcm_pick(c[0], dir_cur[c], s.s2);
      if (dir_cur[c] != TCM_DIR_OUT) begin
        next_s.lvl[c] = 1'b0;
        if (next_s.cap[c] && !tcm_pick(c[0], dir_cur[c], s.s3)) begin
          next_s.cmp_act[c] = s.cnt;
          next_s.cmp_pre[c] = s.cnt;
        end
      end else begin
        case (mode_cur[c])
          TCM_MODE_FREEZE: next_s.lvl[c] = s.lvl[c];
          TCM_MODE_MATCH_HIGH: if (eq[c] && !s.eq_prev[c]) next_s.lvl[c] = 1'b1;
          TCM_MODE_MATCH_LOW: if (eq[c] && !s.eq_prev[c]) next_s.lvl[c] = 1'b0;
          TCM_MODE_MATCH_TOGGLE: begin
            // a match held over prescaled cycles toggles once
            if (eq[c] && !s.eq_prev[c]) next_s.lvl[c] = !s.lvl[c];
          end
          TCM_MODE_FORCE_LOW: next_s.lvl[c] = 1'b0;
          TCM_MODE_FORCE_HIGH: next_s.lvl[c] = 1'b1;
          TCM_MODE_PWM1, TCM_MODE_PWM2: begin
            if ((pwm_res[c] != s.pwm_prev[c]) || (s.mode_prev[c] == TCM_MODE_FREEZE)) begin
              next_s.lvl[c] = pwm_res[c];
            end
          end
          default: next_s.lvl[c] = s.lvl[c];
        endcase
      end
      next_s.eq_prev[c] = eq[c];
      next_s.pwm_prev[c] = pwm_res[c];
      next_s.mode_prev[c] = mode_cur[c];
      // the level keeps running, only the pin view is cleared
      next_s.ref_o[c] = next_s.lvl[c] && !clr[c] && (dir_cur[c] == TCM_DIR_OUT);
    end

    // register writes
    wm = 32'h0000_0000;
    if (wr_go) begin
      next_s.awv = 1'b0;
      next_s.wv = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = tcm_mapped(s.awa) ? TCM_RESP_OKAY : TCM_RESP_SLVERR;
      wm = tcm_merge(tcm_read(s, s.awa), s.wd, s.ws);
      case (s.awa)
        TCM_OFF_CTRL: begin
          next_s.cnt_en = wm[TCM_CTRL_CNT_EN];
          next_s.down = wm[TCM_CTRL_DOWN];
          next_s.spm = wm[TCM_CTRL_SPM];
          next_s.prot = wm[TCM_CTRL_PROT_LSB +: 2];
        end
        TCM_OFF_CHMODE: begin
          for (int c = 0; c < 2; c++) begin
            cm_old = s.chmode[c*TCM_CH_STRIDE +: 8];
            cm_new = cm_old;
            cm_new[TCM_CM_FEN] = wm[c*TCM_CH_STRIDE + TCM_CM_FEN];
            cm_new[TCM_CM_CEN] = wm[c*TCM_CH_STRIDE + TCM_CM_CEN];
            if (!s.chen[c]) begin
              cm_new[TCM_CM_DIR_LSB +: 2] = wm[c*TCM_CH_STRIDE + TCM_CM_DIR_LSB +: 2];
            end
            if (!((s.prot == TCM_PROT_LOCK) && (cm_old[1:0] == TCM_DIR_OUT))) begin
              cm_new[TCM_CM_PEN] = wm[c*TCM_CH_STRIDE + TCM_CM_PEN];
              cm_new[TCM_CM_MODE_LSB +: 3] = wm[c*TCM_CH_STRIDE + TCM_CM_MODE_LSB +: 3];
            end
            next_s.chmode[c*TCM_CH_STRIDE +: 8] = cm_new;
          end
        end
        TCM_OFF_CHEN: begin
          next_s.chen[0] = wm[TCM_CHEN_CH1];
          next_s.chen[1] = wm[TCM_CHEN_CH2];
        end
        TCM_OFF_PSC: next_s.psc = wm[CW-1:0];
        TCM_OFF_ARR: next_s.arr = wm[CW-1:0];
        TCM_OFF_CMP1, TCM_OFF_CMP2: begin
          for (int c = 0; c < 2; c++) begin
            if (s.awa == (c == 0 ? TCM_OFF_CMP1 : TCM_OFF_CMP2)) begin
              next_s.cmp_pre[c] = wm[CW-1:0];
              if (!pen[c]) next_s.cmp_act[c] = wm[CW-1:0];
            end
          end
        end
        default: next_s.chen = next_s.chen;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.chmode <= TCM_RST_CHMODE;
      s.arr <= TCM_RST_ARR[CW-1:0];
      s.psc <= TCM_RST_PSC[CW-1:0];
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic chmode_wr;
  assign chmode_wr = wr_go && (s.awa == TCM_OFF_CHMODE);

  chk_dir_write_lock: assert property (chmode_wr && s.chen[0] |=> s.chmode[1:0] == $past(s.chmode[1:0]))
    else $error("direction changed while channel enabled");
  chk_prot_mode_lock: assert property (chmode_wr && s.prot == TCM_PROT_LOCK && s.chmode[1:0] == TCM_DIR_OUT |=> s.chmode[6:3] == $past(s.chmode[6:3]))
    else $error("locked mode field changed");
  chk_update_restart: assert property (ueg_wr && !s.down |=> s.cnt == '0 && s.psc_cnt == '0 && s.psc == $past(s.psc))
    else $error("update event did not restart counter");
  chk_force_low_ref: assert property (s.chmode[6:4] == TCM_MODE_FORCE_LOW && s.chmode[1:0] == TCM_DIR_OUT |=> !s.ref_o[0])
    else $error("forced low not low");
  chk_force_high_ref: assert property (s.chmode[6:4] == TCM_MODE_FORCE_HIGH && s.chmode[1:0] == TCM_DIR_OUT && !clr[0] |=> s.ref_o[0])
    else $error("forced high not high");
  chk_ext_clear: assert property (clr[0] [*2] |=> !s.ref_o[0])
    else $error("external clear ignored");
  chk_pwm_entry: assert property (s.mode_prev[0] == TCM_MODE_FREEZE && s.chmode[6:4] == TCM_MODE_PWM1 && s.chmode[1:0] == TCM_DIR_OUT && !clr[0] && !trg_edge |=> s.ref_o[0] == $past(s.cnt < s.cmp_act[0]))
    else $error("pwm entry level wrong");
  chk_preload_off: assert property (wr_go && s.awa == TCM_OFF_CMP1 && s.ws == 4'hF && !pen[0] && s.chmode[1:0] == TCM_DIR_OUT |=> s.cmp_act[0] == $past(s.wd[CW-1:0]))
    else $error("immediate compare write lost");
  chk_preload_on: assert property (wr_go && s.awa == TCM_OFF_CMP1 && pen[0] && !ug && s.chmode[1:0] == TCM_DIR_OUT |=> s.cmp_act[0] == $past(s.cmp_act[0]))
    else $error("preloaded value acted early");
  chk_match_high: assert property (s.chmode[6:4] == TCM_MODE_MATCH_HIGH && s.chmode[1:0] == TCM_DIR_OUT && eq[0] && !s.eq_prev[0] |=> s.lvl[0])
    else $error("match did not set level");

  cov_pwm_toggle: cover property (s.chmode[6:4] == TCM_MODE_PWM1 && $rose(s.ref_o[0]) ##[1:300] $fell(s.ref_o[0]));
  cov_update_write: cover property (ueg_wr);
  cov_capture: cover property (s.chmode[1:0] != TCM_DIR_OUT && $rose(s.cap[0]));
  cov_bad_addr: cover property (s.bvalid && s.bresp == TCM_RESP_SLVERR);

endmodule
